// [bridge_fault_flags_sleep_autotx.sv]
// fault flags, sleep control and automatic re-transmit of the bridge
// assumes event inputs are one-cycle pulses synchronous to aclk
`timescale 1ns/1ps
`include "bridge_cfg.svh"
module bridge_fault_flags_sleep_autotx #(
    parameter int TICK_CYCLES = `TICK_CYC
) (
    // clock, reset, enable
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    // axi4-lite slave
    input  wire logic [7:0]          s_awaddr,
    input  wire logic                s_awvalid,
    output logic                     s_awready,
    input  wire logic [31:0]         s_wdata,
    input  wire logic [3:0]          s_wstrb,
    input  wire logic                s_wvalid,
    output logic                     s_wready,
    output logic [1:0]               s_bresp,
    output logic                     s_bvalid,
    input  wire logic                s_bready,
    input  wire logic [7:0]          s_araddr,
    input  wire logic                s_arvalid,
    output logic                     s_arready,
    output logic [31:0]              s_rdata,
    output logic [1:0]               s_rresp,
    output logic                     s_rvalid,
    input  wire logic                s_rready,
    // events and levels from the datapath
    input  wire bridge_pkg::event_s  ev,
    input  wire logic [3:0]          gpio_level,
    input  wire logic                verify_active,
    input  wire logic                load_active,
    input  wire logic                safe_monitor_mode,
    // status and actions
    output logic [7:0]               lockstep_status_byte,
    output logic [7:0]               rolling_seed,
    output logic [3:0]               gpio_out,
    output logic                     error_free,
    output logic                     spi_reject,
    output logic                     alert_packet_req,
    output logic                     replay_tx,
    output logic                     alert_out,
    output logic                     asleep
);
    //------------------------------------------------------------
    // bus slave
    //------------------------------------------------------------
    logic        aw_hold_ff, nxt_aw_hold, w_hold_ff, nxt_w_hold;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic        bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic        do_wr;
    logic [7:0]  wa;
    logic [31:0] wm;
    logic [7:0]  ls_ff, nxt_ls, gs_ff, nxt_gs;
    logic [31:0] slpcfg_ff, nxt_slpcfg, ctl_ff, nxt_ctl;
    logic        req_ff, nxt_req, wake_ff, nxt_wake;
    bridge_pkg::mode_e state_ff, nxt_state;

    // byte enables to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `A_LOCKSTEP) || (a == `A_GEN) || (a == `A_SLPCMD) ||
                 (a == `A_SLPCFG) || (a == `A_OPSTATE) || (a == `A_CTRL);
    endfunction
    // ready drops while a response is pending, so one write at a time
    assign s_awready = ce & ~aw_hold_ff & ~bvalid_ff;
    assign s_wready  = ce & ~w_hold_ff & ~bvalid_ff;
    assign s_arready = ce & ~rvalid_ff;
    assign s_bvalid  = bvalid_ff;
    assign s_bresp   = bresp_ff;
    assign s_rvalid  = rvalid_ff;
    assign s_rdata   = rdata_ff;
    assign s_rresp   = rresp_ff;

    // address and data may arrive in either order
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff & ~s_bready;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff & ~s_rready;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        wa = aw_hold_ff ? awaddr_ff : s_awaddr;
        wm = (w_hold_ff ? wdata_ff : s_wdata) & strb_mask(w_hold_ff ? wstrb_ff : s_wstrb);
        do_wr = ce & ~bvalid_ff & (aw_hold_ff | s_awvalid) & (w_hold_ff | s_wvalid);
        if (s_awvalid && s_awready) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = s_wdata;
            nxt_wstrb  = s_wstrb;
        end
        if (do_wr) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (s_arvalid && s_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = mapped(s_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_araddr)
                `A_LOCKSTEP: nxt_rdata = {24'h000000, ls_ff};
                `A_GEN:     nxt_rdata = {24'h000000, gs_ff};
                `A_SLPCMD:  nxt_rdata = {30'h0, asleep, req_ff};
                `A_SLPCFG:  nxt_rdata = slpcfg_ff;
                `A_OPSTATE: nxt_rdata = {31'h0, wake_ff};
                `A_CTRL:    nxt_rdata = ctl_ff;
                default:    nxt_rdata = `RST_WORD;
            endcase
        end
    end

    // bus registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= `RST_BYTE;
            w_hold_ff  <= 1'b0;
            wdata_ff   <= `RST_WORD;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `RESP_OKAY;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= `RST_WORD;
            rresp_ff   <= `RESP_OKAY;
        end else if (ce) begin
            aw_hold_ff <= nxt_aw_hold;
            awaddr_ff  <= nxt_awaddr;
            w_hold_ff  <= nxt_w_hold;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    //------------------------------------------------------------
    // flags, configuration and sleep control
    //------------------------------------------------------------
    logic [15:0] tick_ff, nxt_tick, bal_ff, nxt_bal;
    logic [7:0]  ap_ff, nxt_ap, seed_ff, nxt_seed, ls_set, gs_set, intv;
    logic        tick, expire, blocked, ap_en, roll_err, spi_rej_evt, clr_ls_hit;
    logic        replay_ff, nxt_replay, apreq_ff, nxt_apreq, rej_ff, nxt_rej;

    assign asleep      = (state_ff == bridge_pkg::ST_SLEEP);
    assign tick        = (tick_ff == 16'(TICK_CYCLES - 1));
    assign expire      = asleep & tick & (bal_ff >= slpcfg_ff[`SC_BAL]);
    assign blocked     = verify_active | load_active | safe_monitor_mode;
    assign spi_rej_evt = ev.spi_access & (asleep | safe_monitor_mode);
    assign roll_err    = ctl_ff[`CT_ROLL] & ev.count_ret_valid &
                         (ev.count_ret != 8'(seed_ff + ctl_ff[`CT_COUNT]));
    assign clr_ls_hit  = do_wr & (wa == `A_LOCKSTEP);
    assign intv        = asleep ? slpcfg_ff[`SC_INTV] : ctl_ff[`CT_INTV];
    assign ap_en       = asleep ? slpcfg_ff[`SC_APEN] : ctl_ff[`CT_APEN];
    // flag sources; a set in the clearing cycle still wins
    always_comb begin
        ls_set = `RST_BYTE;
        gs_set = `RST_BYTE;
        ls_set[`LS_MISMATCH] = ev.pkt_mismatch;
        ls_set[`LS_CORRUPT]  = ev.link_corrupt;
        ls_set[`LS_ROLL]     = roll_err;
        ls_set[`LS_INT]      = |ev.hw_fault;
        gs_set[`GS_GPIO]     = gpio_level != ctl_ff[`CT_GPIO];
        gs_set[`GS_CHAIN]    = (ev.enum_valid & (ev.enum_addr != ctl_ff[`CT_COUNT]))
                               | spi_rej_evt;
        gs_set[`GS_WD]       = ev.wd_misconfig;
        gs_set[`GS_DP]       = ev.datapath_fault;
    end

    // next state of flags, configuration and sleep machine
    always_comb begin
        nxt_ls     = (ls_ff & ~(clr_ls_hit ? wm[7:0] : `RST_BYTE)) | ls_set;
        nxt_gs     = (gs_ff & ~((do_wr && wa == `A_GEN) ? wm[7:0] : `RST_BYTE)) | gs_set;
        nxt_slpcfg = (do_wr && wa == `A_SLPCFG) ? wm : slpcfg_ff;
        nxt_ctl    = (do_wr && wa == `A_CTRL) ? wm : ctl_ff;
        nxt_req    = (do_wr && wa == `A_SLPCMD) ? wm[`SC_REQ] : req_ff;
        nxt_wake   = wake_ff & ~(do_wr && wa == `A_OPSTATE && wm[`OP_WAKE]);
        nxt_state  = state_ff;
        nxt_tick   = tick ? 16'h0000 : 16'(tick_ff + 16'h0001);
        nxt_bal    = bal_ff;
        nxt_ap     = ap_ff;
        nxt_apreq  = 1'b0;
        nxt_seed   = (ctl_ff[`CT_ROLL] && ev.count_launch) ? 8'(seed_ff + 8'h01) : seed_ff;
        nxt_rej    = spi_rej_evt;
        nxt_replay = ev.preamble & ctl_ff[`CT_AUTOTX] &
                     ~asleep & ~safe_monitor_mode;
        if (tick && ap_en) begin
            if (ap_ff >= intv) begin
                nxt_ap    = `RST_BYTE;
                nxt_apreq = 1'b1;
            end else begin
                nxt_ap = 8'(ap_ff + 8'h01);
            end
        end
        unique case (state_ff)
            bridge_pkg::ST_ACTIVE: begin
                if (req_ff && blocked) begin
                    nxt_req = 1'b0;
                end else if (req_ff) begin
                    nxt_state = bridge_pkg::ST_SLEEP;
                    nxt_ap    = `RST_BYTE;
                    nxt_apreq = 1'b0;
                    nxt_bal   = 16'h0000;
                end
            end
            bridge_pkg::ST_SLEEP: begin
                if (expire) begin
                    nxt_state = bridge_pkg::ST_ACTIVE;
                    nxt_req   = 1'b0;
                    nxt_wake  = 1'b1;
                    nxt_ap    = `RST_BYTE;
                end else if (tick) begin
                    nxt_bal = 16'(bal_ff + 16'h0001);
                end
            end
        endcase
    end

    // flag, configuration and sleep registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ls_ff     <= `RST_BYTE;
            gs_ff     <= `RST_BYTE;
            slpcfg_ff <= `RST_WORD;
            ctl_ff    <= `RST_WORD;
            req_ff    <= 1'b0;
            wake_ff   <= 1'b0;
            state_ff  <= bridge_pkg::ST_ACTIVE;
            tick_ff   <= 16'h0000;
            bal_ff    <= 16'h0000;
            ap_ff     <= `RST_BYTE;
            apreq_ff  <= 1'b0;
            seed_ff   <= `RST_BYTE;
            rej_ff    <= 1'b0;
            replay_ff <= 1'b0;
        end else if (ce) begin
            ls_ff     <= nxt_ls;
            gs_ff     <= nxt_gs;
            slpcfg_ff <= nxt_slpcfg;
            ctl_ff    <= nxt_ctl;
            req_ff    <= nxt_req;
            wake_ff   <= nxt_wake;
            state_ff  <= nxt_state;
            tick_ff   <= nxt_tick;
            bal_ff    <= nxt_bal;
            ap_ff     <= nxt_ap;
            apreq_ff  <= nxt_apreq;
            seed_ff   <= nxt_seed;
            rej_ff    <= nxt_rej;
            replay_ff <= nxt_replay;
        end
    end

    // outputs straight from flops, except error_free, which is a gate on two flag flops
    assign lockstep_status_byte = ls_ff;
    assign rolling_seed         = seed_ff;
    assign gpio_out             = ctl_ff[`CT_GPIO];
    assign error_free = ~ls_ff[`LS_CORRUPT] & ~ls_ff[`LS_MISMATCH];
    assign spi_reject           = rej_ff;
    assign alert_packet_req     = apreq_ff;
    assign replay_tx            = replay_ff;
    assign alert_out            = wake_ff;
    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_timer_exit;
        ce && asleep && expire;
    endsequence
    sequence s_woken;
        !asleep && alert_out && !req_ff;
    endsequence
    AST_MISMATCH_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ev.pkt_mismatch |=> lockstep_status_byte[`LS_MISMATCH] && !error_free)
        else $error("mismatch flag not set");
    AST_CORRUPT_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ev.link_corrupt |=> lockstep_status_byte[`LS_CORRUPT] && !error_free)
        else $error("corruption flag not set");
    AST_HW_FAULT: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && (|ev.hw_fault) |=> lockstep_status_byte[`LS_INT])
        else $error("internal fault flag not set");
    AST_SPI_REJECT: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ev.spi_access && (asleep || safe_monitor_mode) |=> spi_reject && gs_ff[`GS_SPI])
        else $error("spi access in sleep or safe mode not rejected");
    AST_SLEEP_REFUSED: assert property (@(posedge aclk) disable iff (!aresetn)
        !asleep && blocked |=> !asleep)
        else $error("sleep entered while blocked");
    AST_TIMER_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
        s_timer_exit |=> s_woken)
        else $error("timer exit did not wake host");
    AST_NO_REPLAY: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(asleep) || $past(safe_monitor_mode) |-> !replay_tx)
        else $error("replay while sleeping or safe");
    AST_REPLAY: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ev.preamble && ctl_ff[`CT_AUTOTX] && !asleep && !safe_monitor_mode |=> replay_tx)
        else $error("preamble did not trigger replay");
    AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        lockstep_status_byte[`LS_MISMATCH] && !clr_ls_hit |=> lockstep_status_byte[`LS_MISMATCH])
        else $error("mismatch flag lost without clear");
endmodule // bridge_fault_flags_sleep_autotx

// [bridge_cfg.svh]
// offsets, field positions, reset values and timing for the fault/sleep block
// assumes a 200 MHz aclk and byte addresses on the low eight address bits
`ifndef BRIDGE_CFG_SVH
`define BRIDGE_CFG_SVH
`define A_LOCKSTEP  8'h00
`define A_GEN       8'h04
`define A_SLPCMD    8'h08
`define A_SLPCFG    8'h0c
`define A_OPSTATE   8'h10
`define A_CTRL      8'h14
`define LS_INT      0
`define LS_ROLL     1
`define LS_MISMATCH 3
`define LS_CORRUPT  5
`define GS_DP       3
`define GS_GPIO     4
`define GS_WD       5
`define GS_CHAIN    6
`define GS_SPI      6
`define OP_WAKE     0
`define CT_AUTOTX   0
`define CT_ROLL     1
`define CT_APEN     2
`define CT_INTV     11:4
`define CT_COUNT    19:12
`define CT_GPIO     23:20
`define SC_APEN     0
`define SC_INTV     15:8
`define SC_BAL      31:16
`define SC_REQ      0
`define RST_WORD    32'h0000_0000
`define RST_BYTE    8'h00
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`define CLK_MHZ     200
`define TICK_NS     1000
`define TICK_CYC    ((`TICK_NS * `CLK_MHZ + 999) / 1000)
`endif

// [bridge_pkg.sv]
// types shared by the fault/sleep block and its bench
// assumes bridge_cfg.svh holds the numeric constants
package bridge_pkg;
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b01,
        ST_SLEEP  = 2'b10
    } mode_e;
    typedef struct packed {
        logic       pkt_mismatch;
        logic       link_corrupt;
        logic [4:0] hw_fault;
        logic       wd_misconfig;
        logic       datapath_fault;
        logic       spi_access;
        logic       preamble;
        logic       count_launch;
        logic       count_ret_valid;
        logic [7:0] count_ret;
        logic       enum_valid;
        logic [7:0] enum_addr;
    } event_s;
endpackage

// [chain_model.sv]
// stand-in for the daisy chain and gpio pins seen by the fault/sleep block
// assumes events come from the bench, one-cycle pulses on aclk
`timescale 1ns/1ps
module chain_model (
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // bench controls
    input  wire bridge_pkg::event_s  ev_in,
    input  wire logic [7:0]          n_dev,
    input  wire logic                slow,
    input  wire logic                bad,
    input  wire logic [3:0]          stuck,
    // block side
    input  wire logic [7:0]          rolling_seed,
    input  wire logic [3:0]          gpio_out,
    output bridge_pkg::event_s       ev,
    output logic [3:0]               gpio_level
);
    logic [3:0] wait_ff;
    logic       pend_ff;
    logic       vld_ff;
    logic [7:0] ret_ff;

    // counter answer: seed plus units in chain, late or wrong on demand
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_ff <= 4'h0;
            pend_ff <= 1'b0;
            vld_ff  <= 1'b0;
            ret_ff  <= 8'h00;
        end else begin
            vld_ff <= 1'b0;
            ret_ff <= ~ret_ff; // return lines toggle when idle
            if (ev_in.count_launch) begin
                pend_ff <= 1'b1;
                wait_ff <= slow ? 4'h5 : 4'h0;
            end else if (pend_ff && wait_ff == 4'h0) begin
                pend_ff <= 1'b0;
                vld_ff  <= 1'b1;
                ret_ff  <= rolling_seed + n_dev + (bad ? 8'h55 : 8'h00);
            end else if (pend_ff) begin
                wait_ff <= wait_ff - 4'h1;
            end
        end
    end

    // merge the counter answer into the bench's events
    always_comb begin
        ev                 = ev_in;
        ev.count_ret_valid = vld_ff;
        ev.count_ret       = ret_ff;
    end

    // a stuck pin shows the wrong level
    assign gpio_level = gpio_out ^ stuck;
endmodule // chain_model

// [bridge_fault_flags_sleep_autotx_tb.sv]
// bench for the fault/sleep block: axi4-lite tasks, event pulses, checks
// assumes chain_model plays the daisy chain and gpio pins
`timescale 1ns/1ps
`include "bridge_cfg.svh"
module bridge_fault_flags_sleep_autotx_tb;
    localparam int T = 4;
    logic aclk, aresetn, ce, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, error_free, spi_reject;
    logic alert_packet_req, replay_tx, alert_out, asleep, slow, bad;
    logic verify_active, load_active, safe_monitor_mode;
    logic [7:0] s_awaddr, s_araddr, lockstep_status_byte, rolling_seed, v;
    logic [31:0] s_wdata, s_rdata, d;
    logic [3:0] s_wstrb, gpio_level, gpio_out, stuck;
    logic [1:0] s_bresp, s_rresp;
    bridge_pkg::event_s ev_in, ev;
    int n_errors, n_tests, cyc, last, gap, cnt_rep, cnt_rej, cnt_alr, c0, c1, t, j, k;

    bridge_fault_flags_sleep_autotx #(.TICK_CYCLES(T)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .ev(ev), .gpio_level(gpio_level), .verify_active(verify_active),
        .load_active(load_active), .safe_monitor_mode(safe_monitor_mode),
        .lockstep_status_byte(lockstep_status_byte), .rolling_seed(rolling_seed),
        .gpio_out(gpio_out), .error_free(error_free), .spi_reject(spi_reject),
        .alert_packet_req(alert_packet_req), .replay_tx(replay_tx),
        .alert_out(alert_out), .asleep(asleep));
    chain_model model_u (.aclk(aclk), .aresetn(aresetn), .ev_in(ev_in), .n_dev(8'h03),
        .slow(slow), .bad(bad), .stuck(stuck), .rolling_seed(rolling_seed),
        .gpio_out(gpio_out), .ev(ev), .gpio_level(gpio_level));

    // ----------------------------------------
    // clock and pulse monitors
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // pulses counted mid-cycle, where registered outputs are settled
    always @(negedge aclk) begin
        cyc <= cyc + 1;
        if (replay_tx) cnt_rep <= cnt_rep + 1;
        if (spi_reject) cnt_rej <= cnt_rej + 1;
        if (alert_packet_req && asleep) begin
            cnt_alr <= cnt_alr + 1;
            gap     <= cyc - last;
            last    <= cyc;
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ready sampled at the negedge equals its value at the next posedge
    task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [1:0] er);
        logic ta, tw, tb, ok;
        int n;
        ok = 1'b0;
        n = 0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= w;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!ok && n < 50) begin
            @(negedge aclk);
            ta = s_awvalid & s_awready;
            tw = s_wvalid & s_wready;
            tb = s_bvalid;
            if (tb) check(s_bresp, er);
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            if (tb) s_bready <= 1'b0;
            ok = tb;
            n++;
        end
        if (!ok) check(32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        logic ta, ok;
        int n;
        ok = 1'b0;
        n = 0;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        while (!ok && n < 50) begin
            @(negedge aclk);
            ta = s_arvalid & s_arready;
            ok = s_rvalid;
            d = s_rdata;
            if (ok) check(s_rresp, er);
            @(posedge aclk);
            if (ta) s_arvalid <= 1'b0;
            if (ok) s_rready <= 1'b0;
            n++;
        end
        if (!ok) check(32'h0, 32'h1);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, `RESP_OKAY);
        check(d, exp);
    endtask

    // one event pulse; ends once its effect and the monitors are settled
    task automatic pulse(input int n, input logic [7:0] val);
        bridge_pkg::event_s e;
        e = '0;
        case (n)
            0: e.pkt_mismatch = 1'b1;
            1: e.link_corrupt = 1'b1;
            2: e.hw_fault = val[4:0];
            3: e.wd_misconfig = 1'b1;
            4: e.datapath_fault = 1'b1;
            5: e.spi_access = 1'b1;
            6: e.preamble = 1'b1;
            7: e.count_launch = 1'b1;
            default: e.enum_valid = 1'b1;
        endcase
        e.enum_addr = val;
        @(posedge aclk);
        ev_in <= e;
        @(posedge aclk);
        ev_in <= '0;
        repeat (2) @(negedge aclk);
    endtask

    // sleep with the given config, wait for the timer wake-up
    task automatic sleep_run(input logic [31:0] cfg);
        wr(`A_SLPCFG, cfg, `RESP_OKAY);
        c0 = cnt_alr;
        wr(`A_SLPCMD, 32'h1, `RESP_OKAY);
        for (t = 0; t < 20 && asleep !== 1'b1; t++) @(negedge aclk);
        c1 = cyc;
        check(asleep, 1'b1);
        for (t = 0; t < 100 && asleep !== 1'b0; t++) @(negedge aclk);
        check((cyc - c1) >= 12 * T && (cyc - c1) <= 13 * T, 1'b1);
        check(alert_out, 1'b1);
        rchk(`A_OPSTATE, 32'h1);
        rchk(`A_SLPCMD, 32'h0);
        wr(`A_OPSTATE, 32'h1, `RESP_OKAY);
        @(negedge aclk);
        check(alert_out, 1'b0);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {ce, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, slow, bad} = '0;
        {verify_active, load_active, safe_monitor_mode, aresetn} = '0;
        {s_awaddr, s_araddr, s_wdata, stuck, ev_in} = '0;
        {n_errors, n_tests, cyc, last, gap, cnt_rep, cnt_rej, cnt_alr} = '0;
        s_wstrb = 4'hf;
        ce = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (j = 0; j < 6; j++) rchk(8'(j * 4), `RST_WORD);
        check(error_free, 1'b1);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        rd(8'h40, `RESP_SLVERR);
        check(d, 32'h0);
        // enable low: an event must leave no trace
        ce <= 1'b0;
        pulse(0, 8'h00);
        check(lockstep_status_byte, 8'h00);
        @(posedge aclk);
        ce <= 1'b1;
        wr(`A_CTRL, 32'h00a0_3017, `RESP_OKAY);
        for (j = 0; j < 7; j++) begin
            k = (j < 2) ? j : 2;
            v = (j < 2) ? 8'h00 : 8'h01 << (j - 2);
            c0 = (j == 0) ? 32'h08 : ((j == 1) ? 32'h20 : 32'h01);
            pulse(k, v);
            repeat (3) @(negedge aclk);
            check(lockstep_status_byte, c0);
            check(error_free, j >= 2);
            wr(`A_LOCKSTEP, c0, `RESP_OKAY);
            rchk(`A_LOCKSTEP, 32'h0);
        end
        for (j = 0; j < 3; j++) begin
            slow = j[0];
            bad = (j == 2);
            pulse(7, 8'h00);
            repeat (8) @(negedge aclk);
            check(lockstep_status_byte, (j == 2) ? 8'h02 : 8'h00);
        end
        wr(`A_LOCKSTEP, 32'h02, `RESP_OKAY);
        stuck <= 4'h1;
        repeat (3) @(negedge aclk);
        rchk(`A_GEN, 32'h10);
        stuck <= 4'h0;
        wr(`A_GEN, 32'h10, `RESP_OKAY);
        pulse(8, 8'h03);
        rchk(`A_GEN, 32'h00);
        pulse(8, 8'h02);
        rchk(`A_GEN, 32'h40);
        wr(`A_GEN, 32'h40, `RESP_OKAY);
        for (j = 0; j < 2; j++) begin
            pulse(3 + j, 8'h00);
            rchk(`A_GEN, j ? 32'h08 : 32'h20);
            wr(`A_GEN, 32'h28, `RESP_OKAY);
        end
        c0 = cnt_rep;
        c1 = cnt_rej;
        pulse(6, 8'h00);
        pulse(5, 8'h00);
        check(cnt_rep - c0, 1);
        check(cnt_rej - c1, 0);
        for (j = 0; j < 3; j++) begin
            @(posedge aclk);
            verify_active <= (j == 0);
            load_active <= (j == 1);
            safe_monitor_mode <= (j == 2);
            wr(`A_SLPCMD, 32'h1, `RESP_OKAY);
            repeat (3) @(negedge aclk);
            check(asleep, 1'b0);
            rchk(`A_SLPCMD, 32'h0);
        end
        c0 = cnt_rep;
        c1 = cnt_rej;
        pulse(6, 8'h00);
        pulse(5, 8'h00);
        check(cnt_rep - c0, 0);
        check(cnt_rej - c1, 1);
        rchk(`A_GEN, 32'h40);
        wr(`A_GEN, 32'h40, `RESP_OKAY);
        @(posedge aclk);
        {verify_active, load_active, safe_monitor_mode} <= 3'b000;
        sleep_run(32'h000c_0100);
        check(cnt_alr - c0, 0);
        sleep_run(32'h000c_0101);
        check(cnt_alr - c0 > 1, 1'b1);
        check(gap, 2 * T);
        wr(`A_CTRL, 32'h00a0_3016, `RESP_OKAY);
        c0 = cnt_rep;
        pulse(6, 8'h00);
        check(cnt_rep - c0, 0);
        conclude();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
endmodule // bridge_fault_flags_sleep_autotx_tb
